// ==== hdl/output_function_mux.sv ====
// One digital output: picks its condition by function code
`timescale 1ns/10ps
module output_function_mux (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic [7:0]                      func_sel_i,
  input  wire logic [servo_status_pkg::NCOND-1:0] cond_i,
  output logic                                 dout_o
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  logic nxt_dout;

  always_comb begin
    nxt_dout = 1'b0;
    case (func_sel_i)
      servo_status_pkg::FUNC_READY:       nxt_dout = cond_i[servo_status_pkg::COND_READY];
      servo_status_pkg::FUNC_SERVO_ON:    nxt_dout = cond_i[servo_status_pkg::COND_SERVO_ON];
      servo_status_pkg::FUNC_ZERO_SPEED:  nxt_dout = cond_i[servo_status_pkg::COND_ZERO_SPEED];
      servo_status_pkg::FUNC_TARGET_SPD:  nxt_dout = cond_i[servo_status_pkg::COND_TARGET_SPD];
      servo_status_pkg::FUNC_IN_POSITION: nxt_dout = cond_i[servo_status_pkg::COND_IN_POSITION];
      servo_status_pkg::FUNC_TORQUE_LIM:  nxt_dout = cond_i[servo_status_pkg::COND_TORQUE_LIM];
      servo_status_pkg::FUNC_FAULT:       nxt_dout = cond_i[servo_status_pkg::COND_FAULT];
      servo_status_pkg::FUNC_BRAKE:       nxt_dout = cond_i[servo_status_pkg::COND_BRAKE];
      servo_status_pkg::FUNC_OVL_PREWARN: nxt_dout = cond_i[servo_status_pkg::COND_OVL_PREWARN];
      servo_status_pkg::FUNC_WARNING:     nxt_dout = cond_i[servo_status_pkg::COND_WARNING];
      servo_status_pkg::FUNC_SPEED_OK:    nxt_dout = cond_i[servo_status_pkg::COND_SPEED_OK];
      // Unknown codes stay inactive, same as code zero
      default:                            nxt_dout = 1'b0; // [RL13]
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dout_o <= servo_status_pkg::RST_OUT;
    end else begin
      dout_o <= nxt_dout;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_none_idle;
    (func_sel_i == servo_status_pkg::FUNC_NONE) |=> !dout_o;
  endproperty
  a_none_idle: assert property (p_none_idle) else $error("unassigned output active"); // [RL13]

endmodule : output_function_mux

// ==== hdl/servo_status_output_selector.sv ====
// Status-output function logic of the servo drive
`timescale 1ns/10ps
// Overview of operation
// [RL1] Code 01: powered and no fault
// [RL2] Code 02: servo enabled and no fault
// [RL3] Code 03: speed below zero-speed threshold
// [RL4] Code 04: speed above target-speed threshold
// [RL5] Code 05: position mode, deviation inside window
// [RL6] Code 06: torque limiting, not torque modes
// [RL7] Code 07: fault, excluding warning conditions
// [RL8] Code 11: limit, comm error or undervoltage
// [RL9] Code 08: brake control with two delays
// [RL10] Code 10: overload time beyond percent warning
// [RL11] Overload beyond allowance raises fault
// [RL12] Code 19: speed mode, speed error small
// [RL13] Code zero output stays inactive
// [RL14] Brake release delayed; engage by delay/speed
module servo_status_output_selector #(
  parameter int NUM_OUT     = 6,
  parameter int SPEED_W     = 16,
  parameter int POS_W       = 24,
  parameter int TIME_W      = 16,
  parameter int DELAY_W     = 16,
  parameter int TICK_CYCLES = servo_status_pkg::TICK_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [NUM_OUT*8-1:0]      output_function_select_i,
  input  wire logic [2:0]                control_mode_i,
  input  wire logic                      ctrl_power_ok_i,
  input  wire logic                      main_power_ok_i,
  input  wire logic                      servo_enable_i,
  input  wire logic                      alarm_active_i,
  input  wire logic                      fwd_limit_i,
  input  wire logic                      rev_limit_i,
  input  wire logic                      comm_error_i,
  input  wire logic                      undervoltage_i,
  input  wire logic                      torque_limiting_i,
  input  wire logic signed [SPEED_W-1:0] speed_fb_i,
  input  wire logic signed [SPEED_W-1:0] speed_cmd_i,
  input  wire logic signed [POS_W-1:0]   pos_deviation_i,
  input  wire logic [TIME_W-1:0]         overload_time_i,
  input  wire logic [TIME_W-1:0]         overload_allow_time_i,
  input  wire logic [SPEED_W-1:0]        zero_speed_threshold_i,
  input  wire logic [SPEED_W-1:0]        target_speed_threshold_i,
  input  wire logic [POS_W-1:0]          position_window_i,
  input  wire logic [SPEED_W-1:0]        speed_window_i,
  input  wire logic [7:0]                overload_warn_percent_i,
  input  wire logic [DELAY_W-1:0]        brake_on_delay_setting_i,
  input  wire logic [DELAY_W-1:0]        brake_off_delay_setting_i,
  output logic [NUM_OUT-1:0]             dout_o,
  output logic                           overload_alarm_o
);

  localparam int NC     = servo_status_pkg::NCOND;
  localparam int PROD_W = TIME_W + 8;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  if (NUM_OUT < 1 || SPEED_W < 2 || POS_W < 2 || TIME_W < 1 || DELAY_W < 1
      || TICK_CYCLES < 1) begin : g_bad_param
    $error("servo_status_output_selector: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Magnitudes and comparisons
  // ---------------------------------------------------------------
  logic [SPEED_W-1:0] spd_mag;
  logic [POS_W-1:0]   pos_mag;
  logic [SPEED_W:0]   spd_err;
  logic [SPEED_W:0]   spd_err_mag;
  logic [PROD_W-1:0]  load_scaled;
  logic [PROD_W-1:0]  warn_scaled;
  logic               warn_cond;
  logic               fault_cond;
  logic               zero_spd;
  logic               ovl_alarm;
  logic               ovl_alarm_ff;

  assign spd_mag = speed_fb_i[SPEED_W-1] ? SPEED_W'(-speed_fb_i) : SPEED_W'(speed_fb_i);
  assign pos_mag = pos_deviation_i[POS_W-1] ? POS_W'(-pos_deviation_i)
                                            : POS_W'(pos_deviation_i);
  assign spd_err = (SPEED_W+1)'({speed_fb_i[SPEED_W-1], speed_fb_i}
                              - {speed_cmd_i[SPEED_W-1], speed_cmd_i});
  assign spd_err_mag = spd_err[SPEED_W] ? (SPEED_W+1)'(-spd_err) : spd_err;
  // Overload time scaled by 100, allowance by the warn percent, so no divider is needed
  assign load_scaled = PROD_W'(overload_time_i) * PROD_W'(servo_status_pkg::PCT_FULL);
  assign warn_scaled = PROD_W'(overload_allow_time_i) * PROD_W'(overload_warn_percent_i);
  assign ovl_alarm   = overload_time_i > overload_allow_time_i; // [RL11]
  assign warn_cond   = fwd_limit_i | rev_limit_i | comm_error_i | undervoltage_i; // [RL8]
  // Warnings are kept out of the fault path by the motion core
  assign fault_cond  = alarm_active_i | ovl_alarm; // [RL7] [RL11]
  assign zero_spd    = spd_mag < zero_speed_threshold_i; // [RL3]
  assign overload_alarm_o = ovl_alarm_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovl_alarm_ff <= 1'b0;
    end else begin
      ovl_alarm_ff <= ovl_alarm; // [RL11]
    end
  end

  // ---------------------------------------------------------------
  // Brake sequencer
  // ---------------------------------------------------------------
  servo_status_pkg::brake_state_t brk_state_ff;
  servo_status_pkg::brake_state_t nxt_brk_state;
  logic [TICK_W-1:0]  tick_cnt_ff;
  logic [DELAY_W-1:0] delay_cnt_ff;
  logic               tick;
  logic               brk_change;

  assign tick       = tick_cnt_ff == TICK_W'(TICK_CYCLES - 1);
  assign brk_change = nxt_brk_state != brk_state_ff;

  always_comb begin
    nxt_brk_state = brk_state_ff;
    unique case (brk_state_ff)
      servo_status_pkg::BRK_ENGAGED: begin
        if (servo_enable_i) nxt_brk_state = servo_status_pkg::BRK_RELEASING;
      end
      servo_status_pkg::BRK_RELEASING: begin
        if (!servo_enable_i) begin
          nxt_brk_state = servo_status_pkg::BRK_ENGAGED;
        end else if (delay_cnt_ff >= brake_on_delay_setting_i) begin
          nxt_brk_state = servo_status_pkg::BRK_RELEASED; // [RL14]
        end
      end
      servo_status_pkg::BRK_RELEASED: begin
        if (!servo_enable_i) nxt_brk_state = servo_status_pkg::BRK_ENGAGING;
      end
      servo_status_pkg::BRK_ENGAGING: begin
        if (servo_enable_i) begin
          nxt_brk_state = servo_status_pkg::BRK_RELEASED;
        end else if (delay_cnt_ff >= brake_off_delay_setting_i || zero_spd) begin
          nxt_brk_state = servo_status_pkg::BRK_ENGAGED; // [RL14]
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      brk_state_ff <= servo_status_pkg::BRK_ENGAGED;
    end else begin
      brk_state_ff <= nxt_brk_state; // [RL9]
    end
  end

  // Delays count in 1 ms ticks; the count restarts on every state change
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || brk_change) begin
      tick_cnt_ff  <= '0;
      delay_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TICK_W'(1);
      if (tick && delay_cnt_ff != '1) delay_cnt_ff <= delay_cnt_ff + DELAY_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Condition vector
  // ---------------------------------------------------------------
  logic [NC-1:0] cond_ff;
  logic          pos_mode;
  logic          trq_mode;
  logic          spd_mode;

  assign pos_mode = control_mode_i == servo_status_pkg::MODE_POS_PULSE;
  assign trq_mode = control_mode_i == servo_status_pkg::MODE_T
                  || control_mode_i == servo_status_pkg::MODE_TORQUE_INT;
  assign spd_mode = control_mode_i == servo_status_pkg::MODE_S
                  || control_mode_i == servo_status_pkg::MODE_SPEED_INT;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cond_ff <= '0;
    end else begin
      cond_ff[servo_status_pkg::COND_READY] <= ctrl_power_ok_i & main_power_ok_i
                                              & ~fault_cond; // [RL1]
      cond_ff[servo_status_pkg::COND_SERVO_ON]  <= servo_enable_i & ~fault_cond; // [RL2]
      cond_ff[servo_status_pkg::COND_ZERO_SPEED] <= zero_spd; // [RL3]
      cond_ff[servo_status_pkg::COND_TARGET_SPD] <= spd_mag > target_speed_threshold_i; // [RL4]
      cond_ff[servo_status_pkg::COND_IN_POSITION] <= pos_mode
                                                  & (pos_mag < position_window_i); // [RL5]
      cond_ff[servo_status_pkg::COND_TORQUE_LIM] <= torque_limiting_i & ~trq_mode; // [RL6]
      cond_ff[servo_status_pkg::COND_FAULT]   <= fault_cond; // [RL7]
      cond_ff[servo_status_pkg::COND_BRAKE]   <= brk_state_ff == servo_status_pkg::BRK_RELEASED
                                           || brk_state_ff == servo_status_pkg::BRK_ENGAGING; // [RL9]
      cond_ff[servo_status_pkg::COND_OVL_PREWARN] <= load_scaled > warn_scaled; // [RL10]
      cond_ff[servo_status_pkg::COND_WARNING] <= warn_cond; // [RL8]
      cond_ff[servo_status_pkg::COND_SPEED_OK] <= spd_mode
                                               & (spd_err_mag < {1'b0, speed_window_i}); // [RL12]
    end
  end

  // ---------------------------------------------------------------
  // Output selectors
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    output_function_mux u_mux (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .func_sel_i (output_function_select_i[g*8 +: 8]),
      .cond_i     (cond_ff),
      .dout_o     (dout_o[g])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_release_due;
    brk_state_ff == servo_status_pkg::BRK_RELEASING && servo_enable_i
      && delay_cnt_ff >= brake_on_delay_setting_i;
  endsequence
  sequence s_engage_due;
    brk_state_ff == servo_status_pkg::BRK_ENGAGING && !servo_enable_i && zero_spd;
  endsequence

  property p_ready;
    (ctrl_power_ok_i && main_power_ok_i && !alarm_active_i && !ovl_alarm)
      |=> cond_ff[servo_status_pkg::COND_READY];
  endproperty
  a_ready: assert property (p_ready) else $error("ready missing"); // [RL1]

  property p_servo_on;
    fault_cond |=> !cond_ff[servo_status_pkg::COND_SERVO_ON];
  endproperty
  a_servo_on: assert property (p_servo_on) else $error("servo on with fault"); // [RL2]

  property p_in_pos;
    !pos_mode |=> !cond_ff[servo_status_pkg::COND_IN_POSITION];
  endproperty
  a_in_pos: assert property (p_in_pos) else $error("in position outside mode"); // [RL5]

  property p_trq_lim;
    trq_mode |=> !cond_ff[servo_status_pkg::COND_TORQUE_LIM];
  endproperty
  a_trq_lim: assert property (p_trq_lim) else $error("torque limit in torque mode"); // [RL6]

  property p_warn_not_fault;
    (warn_cond && !alarm_active_i && !ovl_alarm)
      |=> cond_ff[servo_status_pkg::COND_WARNING] && !cond_ff[servo_status_pkg::COND_FAULT];
  endproperty
  a_warn_not_fault: assert property (p_warn_not_fault) else $error("warning split"); // [RL7] [RL8]

  property p_ovl;
    (overload_time_i > overload_allow_time_i)
      |=> cond_ff[servo_status_pkg::COND_FAULT] && overload_alarm_o;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload alarm missing"); // [RL11]

  property p_prewarn;
    (overload_time_i <= overload_allow_time_i && overload_warn_percent_i == 8'h64)
      |=> !cond_ff[servo_status_pkg::COND_OVL_PREWARN];
  endproperty
  a_prewarn: assert property (p_prewarn) else $error("prewarn at full percent"); // [RL10]

  property p_spok;
    !spd_mode |=> !cond_ff[servo_status_pkg::COND_SPEED_OK];
  endproperty
  a_spok: assert property (p_spok) else $error("speed ok outside mode"); // [RL12]

  property p_brk_release;
    s_release_due |=> brk_state_ff == servo_status_pkg::BRK_RELEASED
                      ##1 cond_ff[servo_status_pkg::COND_BRAKE];
  endproperty
  a_brk_release: assert property (p_brk_release) else $error("brake not released"); // [RL14]

  property p_brk_engage;
    s_engage_due |=> brk_state_ff == servo_status_pkg::BRK_ENGAGED
                     ##1 !cond_ff[servo_status_pkg::COND_BRAKE];
  endproperty
  a_brk_engage: assert property (p_brk_engage) else $error("brake not engaged"); // [RL9]

  property p_brk_off;
    brk_state_ff == servo_status_pkg::BRK_ENGAGED && !servo_enable_i
      |=> !cond_ff[servo_status_pkg::COND_BRAKE];
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("brake released while off"); // [RL9]

endmodule : servo_status_output_selector

// ==== hdl/servo_status_pkg.sv ====
// Constants shared by the status-output function selector
package servo_status_pkg;

  // ---------------------------------------------------------------
  // Output function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FUNC_NONE        = 8'h00;
  localparam logic [7:0] FUNC_READY       = 8'h01;
  localparam logic [7:0] FUNC_SERVO_ON    = 8'h02;
  localparam logic [7:0] FUNC_ZERO_SPEED  = 8'h03;
  localparam logic [7:0] FUNC_TARGET_SPD  = 8'h04;
  localparam logic [7:0] FUNC_IN_POSITION = 8'h05;
  localparam logic [7:0] FUNC_TORQUE_LIM  = 8'h06;
  localparam logic [7:0] FUNC_FAULT       = 8'h07;
  localparam logic [7:0] FUNC_BRAKE       = 8'h08;
  localparam logic [7:0] FUNC_OVL_PREWARN = 8'h10;
  localparam logic [7:0] FUNC_WARNING     = 8'h11;
  localparam logic [7:0] FUNC_SPEED_OK    = 8'h19;

  // ---------------------------------------------------------------
  // Bit positions in the condition vector
  // ---------------------------------------------------------------
  localparam int COND_READY       = 0;
  localparam int COND_SERVO_ON    = 1;
  localparam int COND_ZERO_SPEED  = 2;
  localparam int COND_TARGET_SPD  = 3;
  localparam int COND_IN_POSITION = 4;
  localparam int COND_TORQUE_LIM  = 5;
  localparam int COND_FAULT       = 6;
  localparam int COND_BRAKE       = 7;
  localparam int COND_OVL_PREWARN = 8;
  localparam int COND_WARNING     = 9;
  localparam int COND_SPEED_OK    = 10;
  localparam int NCOND            = 11;

  // ---------------------------------------------------------------
  // Control mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_POS_PULSE  = 3'h0;
  localparam logic [2:0] MODE_PR         = 3'h1;
  localparam logic [2:0] MODE_S          = 3'h2;
  localparam logic [2:0] MODE_T          = 3'h3;
  localparam logic [2:0] MODE_SPEED_INT  = 3'h4;
  localparam logic [2:0] MODE_TORQUE_INT = 3'h5;

  // ---------------------------------------------------------------
  // Timing and scaling
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCT_FULL      = 100;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_OUT = 1'b0;

  typedef enum logic [3:0] {
    BRK_ENGAGED   = 4'b0001,
    BRK_RELEASING = 4'b0010,
    BRK_RELEASED  = 4'b0100,
    BRK_ENGAGING  = 4'b1000
  } brake_state_t;

endpackage : servo_status_pkg

// ==== tb/status_reader.sv ====
// Controller-side model: counts rises of one discrete status input
`timescale 1ns/10ps
module status_reader #(
  parameter int NUM_OUT = 6,
  parameter int WATCH   = 5
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [NUM_OUT-1:0] dout_i,
  input  wire logic               watch_en_i,
  output logic [7:0]              rise_cnt_o
);
  logic prev_ff;
  // Only counts while enabled, so earlier uses of the pin are ignored
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_ff    <= 1'b0;
      rise_cnt_o <= 8'h00;
    end else begin
      prev_ff <= dout_i[WATCH];
      if (watch_en_i && dout_i[WATCH] && !prev_ff) begin
        rise_cnt_o <= rise_cnt_o + 8'h01;
      end
    end
  end
endmodule : status_reader

// ==== tb/test_servo_status_output_selector.sv ====
// Self-checking bench of the status-output selector
`timescale 1ns/10ps
module test_servo_status_output_selector;
  // ----------
  // Stimulus and observation
  // ----------
  logic                clk    = 1'b0;
  logic                rst_n  = 1'b0;
  logic [47:0]         sel    = 48'h0;
  logic [2:0]          mode   = servo_status_pkg::MODE_POS_PULSE;
  logic                cpw    = 1'b0;
  logic                mpw    = 1'b0;
  logic                sen    = 1'b0;
  logic                alm    = 1'b0;
  logic [3:0]          warn   = 4'h0;
  logic                tlim   = 1'b0;
  logic signed [15:0]  fb     = 16'sh0;
  logic signed [15:0]  cmd    = 16'sh0;
  logic signed [23:0]  dev    = 24'sh0;
  logic [15:0]         ovt    = 16'h0;
  logic [15:0]         alw    = 16'h0064;
  logic [7:0]          pct    = 8'h3c;
  logic [5:0]          dout;
  logic                ovl;
  logic [7:0]          rises;
  logic                watch  = 1'b0;
  logic                brk_exp = 1'b0;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  logic [15:0]         zthr   = 16'h000a;
  logic [15:0]         bon    = 16'h0002;
  logic [15:0]         boff   = 16'h0003;
  logic [15:0]         ovt_tab [4] = '{16'd60, 16'd61, 16'd100, 16'd101};

  servo_status_output_selector #(.TICK_CYCLES(4)) DUT (
    .clk_i(clk), .rst_n_i(rst_n), .output_function_select_i(sel),
    .control_mode_i(mode), .ctrl_power_ok_i(cpw), .main_power_ok_i(mpw),
    .servo_enable_i(sen), .alarm_active_i(alm), .fwd_limit_i(warn[0]),
    .rev_limit_i(warn[1]), .comm_error_i(warn[2]), .undervoltage_i(warn[3]),
    .torque_limiting_i(tlim), .speed_fb_i(fb), .speed_cmd_i(cmd),
    .pos_deviation_i(dev), .overload_time_i(ovt), .overload_allow_time_i(alw),
    .zero_speed_threshold_i(zthr), .target_speed_threshold_i(16'h0064),
    .position_window_i(24'h000005), .speed_window_i(16'h0005),
    .overload_warn_percent_i(pct), .brake_on_delay_setting_i(bon),
    .brake_off_delay_setting_i(boff), .dout_o(dout), .overload_alarm_o(ovl));

  status_reader u_reader (.clk_i(clk), .rst_n_i(rst_n), .dout_i(dout),
    .watch_en_i(watch), .rise_cnt_o(rises));

  always #50 clk = ~clk;

  // ----------
  // Reference and checks
  // ----------
  function automatic logic ref_bit(input logic [7:0] code);
    int   s;
    int   d;
    int   e;
    logic flt;
    s = fb;
    d = dev;
    e = int'(fb) - int'(cmd);
    s = (s < 0) ? -s : s;
    d = (d < 0) ? -d : d;
    e = (e < 0) ? -e : e;
    flt = alm | (ovt > alw);
    case (code)
      servo_status_pkg::FUNC_READY:       return cpw & mpw & !flt;
      servo_status_pkg::FUNC_SERVO_ON:    return sen & !flt;
      servo_status_pkg::FUNC_ZERO_SPEED:  return s < int'(zthr);
      servo_status_pkg::FUNC_TARGET_SPD:  return s > 100;
      servo_status_pkg::FUNC_IN_POSITION: return mode == servo_status_pkg::MODE_POS_PULSE && d < 5;
      servo_status_pkg::FUNC_TORQUE_LIM:
        return tlim && mode != servo_status_pkg::MODE_T
               && mode != servo_status_pkg::MODE_TORQUE_INT;
      servo_status_pkg::FUNC_FAULT:       return flt;
      servo_status_pkg::FUNC_BRAKE:       return brk_exp;
      servo_status_pkg::FUNC_OVL_PREWARN: return int'(ovt) * 100 > int'(alw) * int'(pct);
      servo_status_pkg::FUNC_WARNING:     return |warn;
      servo_status_pkg::FUNC_SPEED_OK:
        return (mode == servo_status_pkg::MODE_S || mode == servo_status_pkg::MODE_SPEED_INT)
               && e < 5;
      default:                            return 1'b0;
    endcase
  endfunction : ref_bit

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : cmp

  // dout lags inputs by two edges, overload_alarm by one; n below 2 only once inputs have settled
  task automatic chk(input int n);
    logic [5:0] e;
    repeat (n) @(negedge clk);
    for (int g = 0; g < 6; g++) begin
      e[g] = ref_bit(sel[g*8 +: 8]);
    end
    cmp("dout", {2'b00, e}, {2'b00, dout});
    cmp("overload_alarm", {7'h00, ovt > alw}, {7'h00, ovl});
  endtask : chk

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    sel = {8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
    cpw = 1'b1;
    mpw = 1'b1;
    repeat (20) @(negedge clk);
    cmp("reset dout", 8'h00, {2'b00, dout});
    rst_n = 1'b1;
    cpw = 1'b0;
    mpw = 1'b0;
    chk(3);
    cpw = 1'b1;
    chk(3);
    mpw = 1'b1;
    sen = 1'b1;
    fb = 16'sd50;
    chk(3);
    fb = -16'sd200;
    dev = -24'sd5;
    tlim = 1'b1;
    chk(3);
    fb = 16'sd100;
    dev = 24'sd4;
    chk(3);
    alm = 1'b1;
    mode = servo_status_pkg::MODE_T;
    fb = 16'sd9;
    chk(3);
    mode = servo_status_pkg::MODE_TORQUE_INT;
    fb = -16'sd10;
    chk(3);
    zthr = 16'h000b;
    chk(3);
    alm = 1'b0;
    mode = servo_status_pkg::MODE_S;
    warn = 4'h5;
    chk(3);
    ovt = 16'd101;
    chk(3);
    ovt = 16'd0;
    warn = 4'h0;
    sen = 1'b0;
    fb = 16'sd0;
    chk(6);
    // Code 0 sits on output 5 for the rest of the run
    sel = {8'h00, 8'h19, 8'h10, 8'h08, 8'h11, 8'h07};
    watch = 1'b1;
    chk(3);
    for (int i = 0; i < 4; i++) begin
      warn = 4'(4'h1 << i);
      chk(3);
    end
    warn = 4'h0;
    alm = 1'b1;
    chk(3);
    alm = 1'b0;
    foreach (ovt_tab[k]) begin
      ovt = ovt_tab[k];
      chk(3);
    end
    pct = 8'h64;
    ovt = 16'd100;
    chk(3);
    pct = 8'h3c;
    ovt = 16'd0;
    cmd = 16'sd95;
    fb = 16'sd100;
    chk(3);
    cmd = 16'sd96;
    chk(3);
    mode = servo_status_pkg::MODE_SPEED_INT;
    cmd = 16'sd104;
    chk(3);
    mode = servo_status_pkg::MODE_POS_PULSE;
    chk(3);
    // Brake: 2 ms release delay, 3 ms engage delay, 4 clocks per ms
    fb = 16'sd500;
    sen = 1'b1;
    chk(11);
    brk_exp = 1'b1;
    chk(1);
    chk(19);
    sen = 1'b0;
    chk(15);
    brk_exp = 1'b0;
    chk(1);
    chk(24);
    // Zero release delay: brake output rises four edges after the enable is driven
    bon = 16'h0000;
    sen = 1'b1;
    chk(3);
    brk_exp = 1'b1;
    chk(1);
    chk(21);
    sen = 1'b0;
    fb = 16'sd0;
    brk_exp = 1'b0;
    chk(8);
    cmp("code0 rises", 8'h00, rises);
    end_of_test();
  end

endmodule : test_servo_status_output_selector
